// >>> src/user_cfg_defines.svh
`ifndef USER_CFG_DEFINES_SVH
`define USER_CFG_DEFINES_SVH

`define CMD_FEATURE_CONFIG     8'hD1
`define CMD_INPUT_SENSE_IMP    8'hD2
`define CMD_PHASE_GROUP_CONFIG 8'hD3
`define CMD_GOOD_SIGNAL_DELAY  8'hD4
`define CMD_STARTUP_RAMP_GAIN  8'hD5
`define CMD_INDUCTANCE_VALUE   8'hD6
`define CMD_CAPTURE_FAULT_MASK 8'hD7

`define RST_INPUT_SENSE_IMP    16'hC200
`define RST_GOOD_SIGNAL_DELAY  16'hBA00
`define RST_STARTUP_RAMP_GAIN  8'h03
`define RST_INDUCTANCE_VALUE   16'hB133
`define RST_CAPTURE_FAULT_MASK 16'h0000

`define FC_MIN_DUTY_HI   15
`define FC_MIN_DUTY_LO   11
`define FC_MIN_DUTY_EN   7
`define FC_PRESET_SEL    5
`define FC_LOW_IDLE_HIGH 3
`define FC_GOOD_PUSHPULL 2
`define FC_EXT_TEMP_EN   1
`define FC_EXT_TEMP_FLT  0
`define FC_WRITABLE_MASK 16'hF8AF

`define PG_PHASE_ID_HI 15
`define PG_PHASE_ID_LO 13
`define PG_RAIL_ID_HI  12
`define PG_RAIL_ID_LO  8
`define PG_COUNT_HI    2
`define PG_COUNT_LO    0
`define PG_WRITABLE_MASK 16'hFF07
`define CFM_WRITABLE_MASK 16'h3CFF

`define PHASE_COUNT_FOUR 3'h3
`define PHASE_COUNT_TWO  3'h1
`define CORE_CLK_HZ      20000000
`define DUTY_DENOM       512

`endif

// >>> src/user_cfg_pkg.sv
package user_cfg_pkg;
  typedef struct packed {
    logic       wr;
    logic [7:0] cmd;
    logic [15:0] data;
  } cfg_write_t;

  typedef struct packed {
    logic       ext_temp_enable;
    logic       ext_temp_faults;
    logic       good_push_pull;
    logic       preset_b_select;
    logic       min_duty_enable;
    logic [9:0] min_duty_num;
  } feature_ctrl_t;

  typedef enum logic [1:0] {
    RAMP_OFF  = 2'b00,
    RAMP_UP   = 2'b01,
    RAMP_GOOD = 2'b11
  } ramp_state_t;
endpackage : user_cfg_pkg

// >>> src/converter_user_config_regs.sv
// Notes on behaviour
// - Bit 7 enables a minimum duty of 2*(bits15:11+1)/512; otherwise none.
// - Bit 5 picks the second voltage preset, zero picks the first.
// - While disabled outside four-phase mode, low-side drive follows bit 3: low for 0, high for 1.
// - Bit 2 makes the good pin push-pull, zero makes it open-drain.
// - Bit 1 enables the external temperature sensor input.
// - Bit 0 lets the external sensor decide temperature faults when bit 1 is also set.
// - Feature word resets to the decoded configuration strap value.
// - Sense impedance word is linear-11 milliohms, reset C200h.
// - Phase group: position 15:13, rail 12:8, phases minus one 2:0.
// - After reset rail field equals low five address strap bits, rest zero.
// - Phase offsets spread equally, derived from position and count.
// - Strap configuration fills the phase group word without host writes.
// - Good pin rises a programmed linear-11 millisecond delay after threshold.
// - Ramp gain is a global byte, reset 03h; smaller gain ramps slower.
// - Four-phase group ramps with adaptive loop off until good asserts.
// - Multiphase ramp: no soft-off; shutdown tri-states high side, low side low.
// - Two-phase standalone keeps adaptive loop on and normal ramps.
// - Inductance word is linear-11 microhenries, reset B133h.
// - Set mask bits stop their faults from triggering a snapshot.
// - Mask bit 0 stops output overvoltage from triggering a snapshot.
`include "user_cfg_defines.svh"
module converter_user_config_regs #(
  parameter int          CLK_HZ     = `CORE_CLK_HZ,
  parameter int unsigned TICK_DIV   = CLK_HZ / 1000
) (
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire user_cfg_pkg::cfg_write_t    cfg_wr,
  input  wire logic [7:0]                  rd_cmd,
  output logic      [15:0]                 rd_data,
  output logic                             rd_valid,
  input  wire logic                        strap_load,
  input  wire logic [15:0]                 strap_feature,
  input  wire logic [6:0]                  strap_address,
  input  wire logic                        output_enable,
  input  wire logic                        above_good_threshold,
  input  wire logic [15:0]                 fault_events,
  input  wire logic                        low_side_pwm_active,
  output logic                             low_side_drive,
  output logic                             high_side_drive_oe,
  output logic                             output_good_pin_o,
  output logic                             output_good_pin_oe,
  output logic                             adaptive_loop,
  output logic                             soft_off_allowed,
  output logic                             snapshot_trigger,
  output user_cfg_pkg::feature_ctrl_t      feature_ctrl,
  output logic [2:0]                       phase_slot,
  output logic [2:0]                       phase_slots_total,
  output logic [7:0]                       ramp_gain
);

  logic [15:0] feature_config_reg, feature_config_next;
  logic [15:0] input_sense_impedance_reg, input_sense_impedance_next;
  logic [15:0] phase_group_config_reg, phase_group_config_next;
  logic [15:0] good_signal_delay_reg, good_signal_delay_next;
  logic [7:0]  startup_ramp_gain_reg, startup_ramp_gain_next;
  logic [15:0] inductance_value_reg, inductance_value_next;
  logic [15:0] capture_fault_mask_reg, capture_fault_mask_next;
  logic        strap_sync1_reg, strap_sync_reg, strap_seen_reg, strap_seen_next;

  // Converts a linear-11 word to whole milliseconds, saturating at 1023.
  function automatic logic [9:0] lin11_to_ms(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    logic [31:0]        v;
    e = w[15:11];
    m = w[10:0];
    v = 32'h0;
    if (m > 0)
    begin
      if (e >= 0)
        v = 32'(m) << e;
      else
        v = 32'(m) >> (-e);
    end
    lin11_to_ms = (v > 32'h3FF) ? 10'h3FF : v[9:0];
  endfunction : lin11_to_ms

  // Synchronises the strap-load request coming from the pin decoder.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_sync1_reg <= 1'b0;
      strap_sync_reg  <= 1'b0;
    end
    else
    begin
      strap_sync1_reg <= strap_load;
      strap_sync_reg  <= strap_sync1_reg;
    end
  end

  // Register writes; the first strap load after reset fills feature and phase group words.
  always_comb
  begin
    feature_config_next        = feature_config_reg;
    input_sense_impedance_next = input_sense_impedance_reg;
    phase_group_config_next    = phase_group_config_reg;
    good_signal_delay_next     = good_signal_delay_reg;
    startup_ramp_gain_next     = startup_ramp_gain_reg;
    inductance_value_next      = inductance_value_reg;
    capture_fault_mask_next    = capture_fault_mask_reg;
    strap_seen_next            = strap_seen_reg | strap_sync_reg;
    if (strap_sync_reg && !strap_seen_reg)
    begin
      feature_config_next = strap_feature & `FC_WRITABLE_MASK;
      phase_group_config_next = {3'h0, strap_address[4:0], 8'h00};
    end
    else if (cfg_wr.wr)
    begin
      unique case (cfg_wr.cmd)
        `CMD_FEATURE_CONFIG:     feature_config_next = cfg_wr.data & `FC_WRITABLE_MASK;
        `CMD_INPUT_SENSE_IMP:    input_sense_impedance_next = cfg_wr.data;
        `CMD_PHASE_GROUP_CONFIG: phase_group_config_next = cfg_wr.data & `PG_WRITABLE_MASK;
        `CMD_GOOD_SIGNAL_DELAY:  good_signal_delay_next = cfg_wr.data;
        `CMD_STARTUP_RAMP_GAIN:  startup_ramp_gain_next = cfg_wr.data[7:0];
        `CMD_INDUCTANCE_VALUE:   inductance_value_next = cfg_wr.data;
        `CMD_CAPTURE_FAULT_MASK: capture_fault_mask_next = cfg_wr.data & `CFM_WRITABLE_MASK;
        default:                 strap_seen_next = strap_seen_reg | strap_sync_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      feature_config_reg        <= 16'h0000;
      input_sense_impedance_reg <= `RST_INPUT_SENSE_IMP;
      phase_group_config_reg    <= 16'h0000;
      good_signal_delay_reg     <= `RST_GOOD_SIGNAL_DELAY;
      startup_ramp_gain_reg     <= `RST_STARTUP_RAMP_GAIN;
      inductance_value_reg      <= `RST_INDUCTANCE_VALUE;
      capture_fault_mask_reg    <= `RST_CAPTURE_FAULT_MASK;
      strap_seen_reg            <= 1'b0;
    end
    else
    begin
      feature_config_reg        <= feature_config_next;
      input_sense_impedance_reg <= input_sense_impedance_next;
      phase_group_config_reg    <= phase_group_config_next;
      good_signal_delay_reg     <= good_signal_delay_next;
      startup_ramp_gain_reg     <= startup_ramp_gain_next;
      inductance_value_reg      <= inductance_value_next;
      capture_fault_mask_reg    <= capture_fault_mask_next;
      strap_seen_reg            <= strap_seen_next;
    end
  end

  // Read path answers one cycle after the command; unknown commands read zero.
  logic [15:0] rd_data_next;
  logic        rd_valid_next;
  always_comb
  begin
    rd_valid_next = 1'b1;
    unique case (rd_cmd)
      `CMD_FEATURE_CONFIG:     rd_data_next = feature_config_reg;
      `CMD_INPUT_SENSE_IMP:    rd_data_next = input_sense_impedance_reg;
      `CMD_PHASE_GROUP_CONFIG: rd_data_next = phase_group_config_reg;
      `CMD_GOOD_SIGNAL_DELAY:  rd_data_next = good_signal_delay_reg;
      `CMD_STARTUP_RAMP_GAIN:  rd_data_next = {8'h00, startup_ramp_gain_reg};
      `CMD_INDUCTANCE_VALUE:   rd_data_next = inductance_value_reg;
      `CMD_CAPTURE_FAULT_MASK: rd_data_next = capture_fault_mask_reg;
      default:
      begin
        rd_data_next  = 16'h0000;
        rd_valid_next = 1'b0;
      end
    endcase
  end

  // Power-good delay: millisecond ticks counted once above threshold.
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [9:0]  ms_cnt_reg, ms_cnt_next;
  logic        good_reg, good_next;
  logic        tick;
  assign tick = (tick_cnt_reg == TICK_DIV - 1);
  always_comb
  begin
    tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
    ms_cnt_next   = ms_cnt_reg;
    good_next     = good_reg;
    if (!above_good_threshold || !output_enable)
    begin
      tick_cnt_next = 32'h0;
      ms_cnt_next   = 10'h000;
      good_next     = 1'b0;
    end
    else if (ms_cnt_reg >= lin11_to_ms(good_signal_delay_reg))
      good_next = 1'b1;
    else if (tick)
      ms_cnt_next = ms_cnt_reg + 10'h001;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_cnt_reg <= 32'h0;
      ms_cnt_reg   <= 10'h000;
      good_reg     <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
      ms_cnt_reg   <= ms_cnt_next;
      good_reg     <= good_next;
    end
  end

  // Ramp mode state: four-phase groups hold the adaptive loop off until good.
  user_cfg_pkg::ramp_state_t ramp_reg, ramp_next;
  logic multi_mode;
  assign multi_mode = (phase_group_config_reg[`PG_COUNT_HI:`PG_COUNT_LO] == `PHASE_COUNT_FOUR);
  always_comb
  begin
    ramp_next = ramp_reg;
    unique case (ramp_reg)
      user_cfg_pkg::RAMP_OFF:  if (output_enable) ramp_next = user_cfg_pkg::RAMP_UP;
      user_cfg_pkg::RAMP_UP:
        if (!output_enable) ramp_next = user_cfg_pkg::RAMP_OFF;
        else if (good_reg) ramp_next = user_cfg_pkg::RAMP_GOOD;
      user_cfg_pkg::RAMP_GOOD: if (!output_enable) ramp_next = user_cfg_pkg::RAMP_OFF;
      default: ramp_next = user_cfg_pkg::RAMP_OFF;
    endcase
  end

  // Registered outputs.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ramp_reg           <= user_cfg_pkg::RAMP_OFF;
      rd_data            <= 16'h0000;
      rd_valid           <= 1'b0;
      low_side_drive     <= 1'b0;
      high_side_drive_oe <= 1'b0;
      output_good_pin_o  <= 1'b0;
      output_good_pin_oe <= 1'b1;
      adaptive_loop      <= 1'b1;
      soft_off_allowed   <= 1'b1;
      snapshot_trigger   <= 1'b0;
      feature_ctrl       <= '0;
      phase_slot         <= 3'h0;
      phase_slots_total  <= 3'h1;
      ramp_gain          <= `RST_STARTUP_RAMP_GAIN;
    end
    else
    begin
      ramp_reg <= ramp_next;
      rd_data  <= rd_data_next;
      rd_valid <= rd_valid_next;
      if (output_enable)
        low_side_drive <= low_side_pwm_active;
      else if (multi_mode)
        low_side_drive <= 1'b0;
      else
        low_side_drive <= feature_config_reg[`FC_LOW_IDLE_HIGH];
      high_side_drive_oe <= output_enable | ~multi_mode;
      output_good_pin_o  <= good_reg;
      output_good_pin_oe <= feature_config_reg[`FC_GOOD_PUSHPULL] | ~good_reg;
      adaptive_loop <= ~multi_mode | (ramp_next == user_cfg_pkg::RAMP_GOOD);
      soft_off_allowed <= ~multi_mode;
      snapshot_trigger <= |(fault_events & ~capture_fault_mask_reg);
      feature_ctrl.ext_temp_enable <= feature_config_reg[`FC_EXT_TEMP_EN];
      feature_ctrl.ext_temp_faults <= feature_config_reg[`FC_EXT_TEMP_EN]
                                    & feature_config_reg[`FC_EXT_TEMP_FLT];
      feature_ctrl.good_push_pull  <= feature_config_reg[`FC_GOOD_PUSHPULL];
      feature_ctrl.preset_b_select <= feature_config_reg[`FC_PRESET_SEL];
      feature_ctrl.min_duty_enable <= feature_config_reg[`FC_MIN_DUTY_EN];
      feature_ctrl.min_duty_num <= feature_config_reg[`FC_MIN_DUTY_EN]
        ? {4'h0, feature_config_reg[`FC_MIN_DUTY_HI:`FC_MIN_DUTY_LO], 1'b0} + 10'h002
        : 10'h000;
      phase_slot <= phase_group_config_reg[`PG_PHASE_ID_HI:`PG_PHASE_ID_LO];
      phase_slots_total <= phase_group_config_reg[`PG_COUNT_HI:`PG_COUNT_LO] + 3'h1;
      ramp_gain <= startup_ramp_gain_reg;
    end
  end

  // Checks.
  property p_ls_idle;
    @(posedge core_clk) disable iff (!resetn)
    (!output_enable && !multi_mode) |=> low_side_drive == $past(feature_config_reg[3]);
  endproperty
  a_ls_idle: assert property (p_ls_idle) else $error("idle low side wrong");
  property p_mask;
    @(posedge core_clk) disable iff (!resetn)
    (fault_events == 16'h0001 && capture_fault_mask_reg[0]) |=> !snapshot_trigger;
  endproperty
  a_mask: assert property (p_mask) else $error("masked fault triggered");
  property p_snap;
    @(posedge core_clk) disable iff (!resetn)
    (|(fault_events & ~capture_fault_mask_reg)) |=> snapshot_trigger;
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot missed");
  property p_loop;
    @(posedge core_clk) disable iff (!resetn)
    (ramp_reg == user_cfg_pkg::RAMP_UP && multi_mode && !good_reg) |=> !adaptive_loop;
  endproperty
  a_loop: assert property (p_loop) else $error("loop on during ramp");
  property p_two;
    @(posedge core_clk) disable iff (!resetn)
    !multi_mode |=> adaptive_loop && soft_off_allowed;
  endproperty
  a_two: assert property (p_two) else $error("standalone loop off");
  property p_good_drop;
    @(posedge core_clk) disable iff (!resetn)
    !above_good_threshold |=> ##1 !output_good_pin_o;
  endproperty
  a_good_drop: assert property (p_good_drop) else $error("good held");
  property p_od;
    @(posedge core_clk) disable iff (!resetn)
    (good_reg && !feature_config_reg[2]) |=> !output_good_pin_oe;
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
  property p_duty;
    @(posedge core_clk) disable iff (!resetn)
    !feature_config_reg[7] |=> feature_ctrl.min_duty_num == 10'h000;
  endproperty
  a_duty: assert property (p_duty) else $error("min duty while off");
  c_good: cover property (@(posedge core_clk) $rose(output_good_pin_o));
  c_snap: cover property (@(posedge core_clk) $rose(snapshot_trigger));
  c_multi: cover property (@(posedge core_clk) multi_mode && $rose(adaptive_loop));
endmodule : converter_user_config_regs

// >>> verification/power_stage_model.sv
module power_stage_model #(
  parameter logic [15:0] STRAP_FEAT = 16'hFFFF,
  parameter logic [6:0]  STRAP_ADDR = 7'h5A,
  parameter int          RISE_CYC   = 10
) (
  input  wire logic  core_clk,
  input  wire logic  resetn,
  input  wire logic  output_enable,
  output logic       strap_load,
  output logic [15:0] strap_feature,
  output logic [6:0] strap_address,
  output logic       above_good_threshold,
  output logic       low_side_pwm_active
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned strap_cnt;
  int unsigned rise_cnt;

  // Counts the strap settling time and the output ramp while enabled.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_cnt <= 0;
      rise_cnt  <= 0;
    end
    else
    begin
      if (strap_cnt < 4)
        strap_cnt <= strap_cnt + 1;
      rise_cnt <= output_enable ? rise_cnt + 1 : 0;
    end
  end

  // Strap pins show the inverse until the load level rises, so an early capture is caught.
  assign strap_load    = (strap_cnt == 4);
  assign strap_feature = strap_load ? STRAP_FEAT : ~STRAP_FEAT;
  assign strap_address = strap_load ? STRAP_ADDR : ~STRAP_ADDR;
  // The output crosses the good threshold a fixed time into the ramp and drops at once.
  assign above_good_threshold = output_enable && (rise_cnt >= RISE_CYC);
  assign low_side_pwm_active  = output_enable && rise_cnt[0];
endmodule : power_stage_model

// >>> verification/tb_converter_user_config_regs.sv
`include "user_cfg_defines.svh"
module tb_converter_user_config_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;
  localparam logic [15:0] MASK [7] = '{16'hF8AF, 16'hFFFF, 16'hFF07, 16'hFFFF, 16'h00FF,
                                       16'hFFFF, 16'h3CFF};
  localparam int FLT [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 13};
  logic core_clk, resetn, rd_valid, strap_load, output_enable, above_good_threshold;
  logic low_side_pwm_active, low_side_drive, high_side_drive_oe, output_good_pin_o;
  logic output_good_pin_oe, adaptive_loop, soft_off_allowed, snapshot_trigger, hit;
  user_cfg_pkg::cfg_write_t    cfg_wr;
  user_cfg_pkg::feature_ctrl_t feature_ctrl;
  logic [7:0]  rd_cmd, ramp_gain;
  logic [15:0] rd_data, strap_feature, fault_events, fv;
  logic [6:0]  strap_address;
  logic [2:0]  phase_slot, phase_slots_total;
  logic [15:0] wv [7];
  logic [15:0] exp_q [$];
  logic [31:0] seed = 32'h4880;
  int          err_total, n_tests, cyc, n;

  converter_user_config_regs #(.TICK_DIV(TICK)) converter_user_config_regs_i (
    .core_clk, .resetn, .cfg_wr, .rd_cmd, .rd_data, .rd_valid, .strap_load, .strap_feature,
    .strap_address, .output_enable, .above_good_threshold, .fault_events,
    .low_side_pwm_active, .low_side_drive, .high_side_drive_oe, .output_good_pin_o,
    .output_good_pin_oe, .adaptive_loop, .soft_off_allowed, .snapshot_trigger,
    .feature_ctrl, .phase_slot, .phase_slots_total, .ramp_gain);
  power_stage_model power_stage_model_i (.core_clk, .resetn, .output_enable, .strap_load,
    .strap_feature, .strap_address, .above_good_threshold, .low_side_pwm_active);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic e, input logic g);
    chk_word(what, {15'h0000, e}, {15'h0000, g});
  endtask : chk_bit

  task automatic reg_write(input logic [7:0] c, input logic [15:0] d);
    @(posedge core_clk);
    cfg_wr <= '{wr: 1'b1, cmd: c, data: d};
    rd_cmd <= 8'h00;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] c, input logic [15:0] e);
    @(posedge core_clk);
    cfg_wr.wr <= 1'b0;
    rd_cmd    <= c;
    exp_q.push_back(e);
  endtask : reg_read

  task automatic quiet(input int k);
    repeat (k)
    begin
      @(posedge core_clk);
      cfg_wr.wr <= 1'b0;
      rd_cmd    <= 8'h00;
    end
    @(negedge core_clk);
  endtask : quiet

  task automatic pulse_fault(input int b, output logic seen);
    seen = 1'b0;
    @(posedge core_clk);
    cfg_wr.wr    <= 1'b0;
    fault_events <= 16'h0001 << b;
    @(posedge core_clk);
    fault_events <= 16'h0000;
    repeat (3)
    begin
      @(negedge core_clk);
      seen = seen | snapshot_trigger;
    end
  endtask : pulse_fault

  task automatic enable_and_wait_threshold();
    @(posedge core_clk);
    output_enable <= 1'b1;
    for (n = 0; n < 60 && above_good_threshold !== 1'b1; n++)
      @(negedge core_clk);
  endtask : enable_and_wait_threshold

  // The clock runs free for the whole run.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // A hung run is cut short and reported as a mismatch.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      print_verdict();
    end
  end

  // Each valid read answer is matched against the oldest noted expectation.
  always @(negedge core_clk)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk_bit("read answer expected", 1'b0, 1'b1);
      else
        chk_word("rd_data", exp_q.pop_front(), rd_data);
    end

  // Main sequence of scenarios.
  initial
  begin
    cfg_wr        = '0;
    rd_cmd        = 8'h00;
    output_enable = 1'b0;
    fault_events  = 16'h0000;
    resetn        = 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    reg_read(`CMD_INPUT_SENSE_IMP, 16'hC200);
    reg_read(`CMD_GOOD_SIGNAL_DELAY, 16'hBA00);
    reg_read(`CMD_STARTUP_RAMP_GAIN, 16'h0003);
    reg_read(`CMD_INDUCTANCE_VALUE, 16'hB133);
    reg_read(`CMD_CAPTURE_FAULT_MASK, 16'h0000);
    quiet(1);
    @(posedge core_clk);
    rd_cmd <= 8'hD8;
    quiet(1);
    chk_bit("unmapped rd_valid", 1'b0, rd_valid);
    chk_word("unmapped rd_data", 16'h0000, rd_data);
    chk_word("ramp_gain", 16'h0003, {8'h00, ramp_gain});
    quiet(6);
    reg_read(`CMD_FEATURE_CONFIG, 16'hF8AF);
    reg_read(`CMD_PHASE_GROUP_CONFIG, 16'h1A00);
    // Back-to-back random writes to every word, then back-to-back readback.
    for (int i = 0; i < 7; i++)
    begin
      seed  = xs(seed);
      wv[i] = seed[15:0];
      reg_write(8'hD1 + 8'(i), wv[i]);
    end
    for (int i = 0; i < 7; i++)
      reg_read(8'hD1 + 8'(i), wv[i] & MASK[i]);
    quiet(2);
    chk_word("ramp_gain", {8'h00, wv[4][7:0]}, {8'h00, ramp_gain});
    chk_word("phase_slot", {13'h0000, wv[2][15:13]}, {13'h0000, phase_slot});
    chk_word("slots_total", {13'h0000, 3'(wv[2][2:0] + 3'h1)},
             {13'h0000, phase_slots_total});
    // Feature bits decoded from random words, the last one at full field values.
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      fv   = (i == 5) ? 16'hFFFF : seed[15:0] ^ {8'h00, i[0], 7'h00};
      reg_write(`CMD_FEATURE_CONFIG, fv);
      quiet(2);
      chk_bit("min_duty_enable", fv[7], feature_ctrl.min_duty_enable);
      if (fv[7])
        chk_word("min_duty_num", 16'((fv[15:11] + 16'h1) * 16'h2),
                 {6'h00, feature_ctrl.min_duty_num});
      chk_bit("preset_b_select", fv[5], feature_ctrl.preset_b_select);
      chk_bit("good_push_pull", fv[2], feature_ctrl.good_push_pull);
      chk_bit("ext_temp_enable", fv[1], feature_ctrl.ext_temp_enable);
      chk_bit("ext_temp_faults", fv[1] & fv[0], feature_ctrl.ext_temp_faults);
      reg_read(`CMD_FEATURE_CONFIG, fv & `FC_WRITABLE_MASK);
    end
    // Four-phase member: shutdown state, ramp without adaptive loop, delayed good.
    reg_write(`CMD_PHASE_GROUP_CONFIG, 16'h0103);
    reg_write(`CMD_FEATURE_CONFIG, 16'h000C);
    reg_write(`CMD_GOOD_SIGNAL_DELAY, 16'h0003);
    quiet(3);
    chk_bit("high side oe", 1'b0, high_side_drive_oe);
    chk_bit("low side idle", 1'b0, low_side_drive);
    chk_bit("soft off", 1'b0, soft_off_allowed);
    enable_and_wait_threshold();
    chk_bit("adaptive in ramp", 1'b0, adaptive_loop);
    for (n = 0; n < 60 && output_good_pin_o !== 1'b1; n++)
      @(negedge core_clk);
    chk_bit("good delay", 1'b1, n >= 3 * TICK && n <= 5 * TICK + 4);
    chk_bit("push pull oe", 1'b1, output_good_pin_oe);
    quiet(3);
    chk_bit("adaptive after good", 1'b1, adaptive_loop);
    @(posedge core_clk);
    output_enable <= 1'b0;
    // Two-phase standalone: idle low side follows the feature bit, loop always on.
    reg_write(`CMD_PHASE_GROUP_CONFIG, 16'h2101);
    reg_write(`CMD_FEATURE_CONFIG, 16'h0008);
    quiet(3);
    chk_bit("low side idle", 1'b1, low_side_drive);
    chk_bit("adaptive standalone", 1'b1, adaptive_loop);
    chk_bit("soft off", 1'b1, soft_off_allowed);
    chk_bit("high side oe", 1'b1, high_side_drive_oe);
    enable_and_wait_threshold();
    for (n = 0; n < 60 && output_good_pin_oe !== 1'b0; n++)
      @(negedge core_clk);
    chk_bit("open drain oe", 1'b0, output_good_pin_oe);
    chk_bit("adaptive standalone", 1'b1, adaptive_loop);
    @(posedge core_clk);
    output_enable <= 1'b0;
    reg_write(`CMD_FEATURE_CONFIG, 16'h0000);
    quiet(3);
    chk_bit("low side idle", 1'b0, low_side_drive);
    // Each maskable fault (bits 0-7, 10-13) is stopped by its own mask bit and passes when only it is unmasked.
    foreach (FLT[k])
    begin
      reg_write(`CMD_CAPTURE_FAULT_MASK, 16'h0001 << FLT[k]);
      pulse_fault(FLT[k], hit);
      chk_bit("masked trigger", 1'b0, hit);
      reg_write(`CMD_CAPTURE_FAULT_MASK, ~(16'h0001 << FLT[k]) & 16'h3CFF);
      pulse_fault(FLT[k], hit);
      chk_bit("unmasked trigger", 1'b1, hit);
    end
    quiet(2);
    chk_word("reads left", 16'h0000, 16'(exp_q.size()));
    print_verdict();
  end
endmodule : tb_converter_user_config_regs
